// ### logic/scs_pkg.sv
/*
 sensor channel configuration: register map, reset values, field
 positions, measurement slots and sequencer states.
 assumes an 8-bit register port addressed by byte.
*/
package scs_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CHANNEL_LIST = 8'h01;
   localparam logic [7:0] OFS_LED_ONE_TWO = 8'h02;
   localparam logic [7:0] OFS_LED_THREE = 8'h03;
   localparam logic [7:0] OFS_ALIGNMENT = 8'h05;
   localparam logic [7:0] OFS_RESULT_FIRST = 8'h22;
   localparam logic [7:0] OFS_RESULT_LAST = 8'h2d;
   localparam logic [7:0] OFS_SEQ_STATUS = 8'h30;

   // -----------------------------------------------------------------
   // reset values and writable bits
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_CHANNEL_LIST = 8'h00;
   localparam logic [7:0] RST_LED_ONE_TWO = 8'h21;
   localparam logic [7:0] RST_LED_THREE = 8'h04;
   localparam logic [7:0] RST_ALIGNMENT = 8'h00;
   localparam logic [7:0] MASK_CHANNEL_LIST = 8'h77;
   localparam logic [7:0] MASK_LED_ONE_TWO = 8'h77;
   localparam logic [7:0] MASK_LED_THREE = 8'h07;
   localparam logic [7:0] MASK_ALIGNMENT = 8'h70;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int BIT_PROX_ONE_ON = 0;
   localparam int BIT_PROX_TWO_ON = 1;
   localparam int BIT_PROX_THREE_ON = 2;
   localparam int BIT_VISIBLE_ON = 4;
   localparam int BIT_INFRARED_ON = 5;
   localparam int BIT_AUXILIARY_ON = 6;
   localparam int POS_DRIVERS_ONE = 0;
   localparam int POS_DRIVERS_TWO = 4;
   localparam int POS_DRIVERS_THREE = 0;
   localparam int BIT_PROX_ONE_LOW = 4;
   localparam int BIT_PROX_TWO_LOW = 5;
   localparam int BIT_PROX_THREE_LOW = 6;

   // -----------------------------------------------------------------
   // measurement slots, also result memory word index
   // -----------------------------------------------------------------
   localparam logic [2:0] SLOT_VISIBLE = 3'h0;
   localparam logic [2:0] SLOT_INFRARED = 3'h1;
   localparam logic [2:0] SLOT_PROX_ONE = 3'h2;
   localparam logic [2:0] SLOT_PROX_TWO = 3'h3;
   localparam logic [2:0] SLOT_PROX_THREE = 3'h4;
   localparam logic [2:0] SLOT_AUXILIARY = 3'h5;
   localparam int RESULT_WORDS = 6;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_PICK = 2'b01,
      ST_CONVERT = 2'b10,
      ST_STORE = 2'b11
   } scs_state_type;

endpackage

// ### logic/scs_mem_if.sv
/*
 result memory port bundle between sequencer, bus side and memory.
 assumes all users run on mclk.
*/
`timescale 1ns/10ps
interface scs_mem_if;
   logic wrEn;
   logic [2:0] wrAddr;
   logic [15:0] wrData;
   logic rdEn;
   logic [2:0] rdAddr;
   logic [15:0] rdData;

   modport user
   (
      output wrEn, wrAddr, wrData, rdEn, rdAddr,
      input rdData
   );
   modport memory
   (
      input wrEn, wrAddr, wrData, rdEn, rdAddr,
      output rdData
   );
endinterface

// ### logic/scs_result_mem.sv
/*
 six-word result store, one write and one registered read port.
 assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module scs_result_mem
   import scs_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   scs_mem_if.memory mem
);

   logic [15:0] store [0:RESULT_WORDS-1];
   logic [15:0] rdData_reg;

   // -----------------------------------------------------------------
   // write and read ports
   // -----------------------------------------------------------------
   always_ff @(posedge mclk)
   begin
      if (mem.wrEn)
      begin
         store[mem.wrAddr] <= mem.wrData;
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdData_reg <= 16'h0000;
      end
      else if (mem.rdEn)
      begin
         rdData_reg <= store[mem.rdAddr];
      end
   end

   assign mem.rdData = rdData_reg;

endmodule

// ### logic/scs_align.sv
/*
 picks sixteen of the seventeen converter bits and holds them.
 assumes load is one cycle and comes from mclk logic.
*/
`timescale 1ns/10ps
module scs_align
   import scs_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic load,
   input wire logic lowBits,
   input wire logic [16:0] sample,
   output logic [15:0] word
);

   logic [15:0] word_reg;

   // -----------------------------------------------------------------
   // alignment
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         word_reg <= 16'h0000;
      end
      else if (load)
      begin
         word_reg <= lowBits ? sample[15:0] : sample[16:1];
      end
   end

   assign word = word_reg;

   a_align_low: assert property (
      @(posedge mclk) disable iff (!arst_n)
      load && lowBits |=> word == $past(sample[15:0]))
      else $error("low alignment lost");
   a_align_high: assert property (
      @(posedge mclk) disable iff (!arst_n)
      load && !lowBits |=> word == $past(sample[16:1]))
      else $error("high alignment lost");

endmodule

// ### logic/scs_channel_config.sv
/*
 channel configuration registers and the measurement sequencer that
 walks the enabled channels, pulses the chosen led drivers and stores
 aligned results.
 assumes a converter on mclk answering adcStart with a one-cycle
 adcDone and a 17-bit sample, and a register master on mclk.
*/
`timescale 1ns/10ps
// Summary of operation
// - channel list bit 6 measures auxiliary input into auxiliary result.
// - channel list bit 5 measures infrared light into infrared result.
// - channel list bit 4 measures visible light into visible result.
// - bits 0, 1, 2 enable proximity channels one, two, three.
// - led register one bits 2:0 pick drivers for proximity one.
// - led register one bits 6:4 pick drivers for proximity two.
// - led register three bits 2:0 pick drivers for proximity three.
// - alignment bit set reports low 16 bits, else upper 16.
module scs_channel_config
   import scs_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [7:0] regRdData,
   input wire logic measureStart,
   output logic adcStart,
   output logic [2:0] adcChannel,
   input wire logic adcDone,
   input wire logic [16:0] adcSample,
   output logic [2:0] ledDrive,
   output logic seqBusy,
   output logic measureDone
);

   // -----------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------
   function automatic logic slotOn(input logic [7:0] list,
                                   input logic [2:0] slot);
      case (slot)
         SLOT_VISIBLE: return list[BIT_VISIBLE_ON];
         SLOT_INFRARED: return list[BIT_INFRARED_ON];
         SLOT_PROX_ONE: return list[BIT_PROX_ONE_ON];
         SLOT_PROX_TWO: return list[BIT_PROX_TWO_ON];
         SLOT_PROX_THREE: return list[BIT_PROX_THREE_ON];
         SLOT_AUXILIARY: return list[BIT_AUXILIARY_ON];
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [2:0] slotLeds(input logic [7:0] oneTwo,
                                           input logic [7:0] three,
                                           input logic [2:0] slot);
      case (slot)
         SLOT_PROX_ONE: return oneTwo[POS_DRIVERS_ONE +: 3];
         SLOT_PROX_TWO: return oneTwo[POS_DRIVERS_TWO +: 3];
         SLOT_PROX_THREE: return three[POS_DRIVERS_THREE +: 3];
         default: return 3'h0;
      endcase
   endfunction

   function automatic logic slotLow(input logic [7:0] align,
                                    input logic [2:0] slot);
      case (slot)
         SLOT_PROX_ONE: return align[BIT_PROX_ONE_LOW];
         SLOT_PROX_TWO: return align[BIT_PROX_TWO_LOW];
         SLOT_PROX_THREE: return align[BIT_PROX_THREE_LOW];
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic inResult(input logic [7:0] addr);
      return addr >= OFS_RESULT_FIRST && addr <= OFS_RESULT_LAST;
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic [7:0] channel_enable_list_reg;
   logic [7:0] ledOneTwo_reg;
   logic [7:0] ledThree_reg;
   logic [7:0] align_reg;
   logic [7:0] cfgRd_reg;
   logic [7:0] cfgRd_next;
   logic rdValid_reg;
   logic rdFromMem_reg;
   logic rdHigh_reg;
   logic [7:0] resultIndex;
   scs_state_type state_reg;
   logic [2:0] slot_reg;
   logic adcStart_reg;
   logic [2:0] ledDrive_reg;
   logic done_reg;
   logic lastSlot;
   logic [15:0] alignedWord;
   logic ledThreeWritten_reg;

   scs_mem_if memBus ();

   // -----------------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         channel_enable_list_reg <= RST_CHANNEL_LIST;
         ledOneTwo_reg <= RST_LED_ONE_TWO;
         ledThree_reg <= RST_LED_THREE;
         align_reg <= RST_ALIGNMENT;
      end
      else if (regWrStrobe)
      begin
         case (regAddr)
            OFS_CHANNEL_LIST: channel_enable_list_reg <= regWrData & MASK_CHANNEL_LIST;
            OFS_LED_ONE_TWO: ledOneTwo_reg <= regWrData & MASK_LED_ONE_TWO;
            OFS_LED_THREE: ledThree_reg <= regWrData & MASK_LED_THREE;
            OFS_ALIGNMENT: align_reg <= regWrData & MASK_ALIGNMENT;
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ledThreeWritten_reg <= 1'b0;
      end
      else if (regWrStrobe && regAddr == OFS_LED_THREE)
      begin
         ledThreeWritten_reg <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always_comb
   begin
      case (regAddr)
         OFS_CHANNEL_LIST: cfgRd_next = channel_enable_list_reg;
         OFS_LED_ONE_TWO: cfgRd_next = ledOneTwo_reg;
         OFS_LED_THREE: cfgRd_next = ledThree_reg;
         OFS_ALIGNMENT: cfgRd_next = align_reg;
         OFS_SEQ_STATUS: cfgRd_next = {7'h00, seqBusy};
         default: cfgRd_next = 8'h00;
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfgRd_reg <= 8'h00;
         rdValid_reg <= 1'b0;
         rdFromMem_reg <= 1'b0;
         rdHigh_reg <= 1'b0;
      end
      else
      begin
         rdValid_reg <= regRdStrobe;
         if (regRdStrobe)
         begin
            cfgRd_reg <= cfgRd_next;
            rdFromMem_reg <= inResult(regAddr);
            rdHigh_reg <= regAddr[0];
         end
      end
   end

   assign resultIndex = regAddr - OFS_RESULT_FIRST;
   assign memBus.rdEn = regRdStrobe && inResult(regAddr);
   assign memBus.rdAddr = resultIndex[3:1];

   assign regRdData = !rdValid_reg ? 8'h00 :
                      !rdFromMem_reg ? cfgRd_reg :
                      rdHigh_reg ? memBus.rdData[15:8] : memBus.rdData[7:0];

   // -----------------------------------------------------------------
   // measurement sequencer
   // -----------------------------------------------------------------
   assign lastSlot = slot_reg == SLOT_AUXILIARY;

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_reg <= ST_IDLE;
         slot_reg <= SLOT_VISIBLE;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (measureStart && channel_enable_list_reg != 8'h00)
               begin
                  state_reg <= ST_PICK;
                  slot_reg <= SLOT_VISIBLE;
               end
            end
            ST_PICK:
            begin
               if (slotOn(channel_enable_list_reg, slot_reg))
               begin
                  state_reg <= ST_CONVERT;
               end
               else if (lastSlot)
               begin
                  state_reg <= ST_IDLE;
               end
               else
               begin
                  slot_reg <= slot_reg + 3'h1;
               end
            end
            ST_CONVERT:
            begin
               if (adcDone)
               begin
                  state_reg <= ST_STORE;
               end
            end
            ST_STORE:
            begin
               if (lastSlot)
               begin
                  state_reg <= ST_IDLE;
               end
               else
               begin
                  state_reg <= ST_PICK;
                  slot_reg <= slot_reg + 3'h1;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // converter start and led drive
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         adcStart_reg <= 1'b0;
         ledDrive_reg <= 3'h0;
      end
      else
      begin
         adcStart_reg <= state_reg == ST_PICK && slotOn(channel_enable_list_reg, slot_reg);
         if (state_reg == ST_PICK && slotOn(channel_enable_list_reg, slot_reg))
         begin
            ledDrive_reg <= slotLeds(ledOneTwo_reg, ledThree_reg,
                                     slot_reg);
         end
         else if (state_reg == ST_CONVERT && adcDone)
         begin
            ledDrive_reg <= 3'h0;
         end
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= lastSlot && (state_reg == ST_STORE ||
            (state_reg == ST_PICK && !slotOn(channel_enable_list_reg, slot_reg)));
      end
   end

   assign adcStart = adcStart_reg;
   assign adcChannel = slot_reg;
   assign ledDrive = ledDrive_reg;
   assign seqBusy = state_reg != ST_IDLE;
   assign measureDone = done_reg;

   // -----------------------------------------------------------------
   // alignment and result store
   // -----------------------------------------------------------------
   scs_align alignUnit
   (
      .mclk(mclk),
      .arst_n(arst_n),
      .load(state_reg == ST_CONVERT && adcDone),
      .lowBits(slotLow(align_reg, slot_reg)),
      .sample(adcSample),
      .word(alignedWord)
   );

   assign memBus.wrEn = state_reg == ST_STORE;
   assign memBus.wrAddr = slot_reg;
   assign memBus.wrData = alignedWord;

   scs_result_mem resultStore
   (
      .mclk(mclk),
      .arst_n(arst_n),
      .mem(memBus)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   a_aux_stored: assert property (
      @(posedge mclk) disable iff (!arst_n)
      state_reg == ST_STORE && slot_reg == SLOT_AUXILIARY
      |-> channel_enable_list_reg[BIT_AUXILIARY_ON])
      else $error("auxiliary stored while off");
   a_ir_measured: assert property (
      @(posedge mclk) disable iff (!arst_n)
      state_reg == ST_PICK && slot_reg == SLOT_INFRARED
      && channel_enable_list_reg[BIT_INFRARED_ON]
      |=> adcStart && adcChannel == SLOT_INFRARED)
      else $error("infrared not started");
   a_vis_skipped: assert property (
      @(posedge mclk) disable iff (!arst_n)
      state_reg == ST_PICK && slot_reg == SLOT_VISIBLE
      && !channel_enable_list_reg[BIT_VISIBLE_ON]
      |=> !adcStart && slot_reg == SLOT_INFRARED)
      else $error("visible measured while off");
   a_prox_store: assert property (
      @(posedge mclk) disable iff (!arst_n)
      memBus.wrEn |-> slotOn(channel_enable_list_reg, memBus.wrAddr)
      && $past(state_reg == ST_CONVERT && adcDone))
      else $error("proximity store mismatch");
   a_led_one: assert property (
      @(posedge mclk) disable iff (!arst_n)
      state_reg == ST_PICK && slot_reg == SLOT_PROX_ONE
      && channel_enable_list_reg[BIT_PROX_ONE_ON]
      |=> ledDrive == $past(ledOneTwo_reg[2:0]))
      else $error("proximity one drivers wrong");
   a_led_two: assert property (
      @(posedge mclk) disable iff (!arst_n)
      $rose(adcStart) && adcChannel == SLOT_PROX_TWO
      |-> ledDrive == $past(ledOneTwo_reg[6:4]))
      else $error("proximity two drivers wrong");
   a_led_three: assert property (
      @(posedge mclk) disable iff (!arst_n)
      $rose(adcStart) && adcChannel == SLOT_PROX_THREE
      |-> ledDrive == $past(ledThree_reg[2:0]))
      else $error("proximity three drivers wrong");
   a_led3_reset: assert property (
      @(posedge mclk) disable iff (!arst_n)
      regRdStrobe && regAddr == OFS_LED_THREE && !ledThreeWritten_reg
      && !regWrStrobe |=> regRdData == RST_LED_THREE)
      else $error("led three reset value wrong");
   a_reserved_zero: assert property (
      @(posedge mclk) disable iff (!arst_n)
      regRdStrobe && regAddr == OFS_ALIGNMENT
      |=> (regRdData & ~MASK_ALIGNMENT) == 8'h00)
      else $error("reserved bits not zero");

endmodule

// ### dv/scs_adc_model.sv
/*
 converter model: answers adcStart with a one-cycle adcDone and a
 17-bit sample after a settable number of idle cycles.
 assumes mclk and arst_n shared with the block under test.
*/
`timescale 1ns/10ps
module scs_adc_model
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic adcStart,
   input wire logic [2:0] adcChannel,
   input wire logic [7:0] latency,
   output logic adcDone,
   output logic [16:0] adcSample
);
   // ----------------------------------------------------------------
   // conversion timing
   // ----------------------------------------------------------------
   logic pend;
   logic [7:0] cnt;
   logic [2:0] chan;

   always @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pend <= 1'b0;
         cnt <= 8'h00;
         chan <= 3'h0;
         adcDone <= 1'b0;
         adcSample <= 17'h00000;
      end
      else
      begin
         adcDone <= 1'b0;
         // sample line changes every cycle outside its valid cycle
         adcSample <= ~adcSample;
         if (adcStart)
         begin
            pend <= 1'b1;
            chan <= adcChannel;
            cnt <= latency;
         end
         else if (pend && cnt == 8'h00)
         begin
            pend <= 1'b0;
            adcDone <= 1'b1;
            adcSample <= 17'h0c96b ^ {chan, 14'h0000} ^ {14'h0000, chan};
         end
         else if (pend)
            cnt <= cnt - 8'h01;
      end
   end
endmodule

// ### dv/scs_channel_config_bench.sv
/*
 register and measurement tests of the channel configuration block.
 assumes the converter model and a 25 MHz clock.
*/
`timescale 1ns/10ps
module scs_channel_config_bench
   import scs_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic mclk, arst_n, regWrStrobe, regRdStrobe, measureStart;
   logic [7:0] regAddr, regWrData, regRdData, latency;
   logic adcStart, adcDone, seqBusy, measureDone;
   logic [2:0] adcChannel, ledDrive;
   logic [16:0] adcSample;
   logic [2:0] ledSeen [6];
   logic [7:0] startCount [6];
   logic [15:0] expWord [6];
   logic known [6];
   int fails = 0;
   int checked = 0;

   scs_channel_config dut (.mclk(mclk), .arst_n(arst_n),
      .regAddr(regAddr), .regWrData(regWrData),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData), .measureStart(measureStart),
      .adcStart(adcStart), .adcChannel(adcChannel), .adcDone(adcDone),
      .adcSample(adcSample), .ledDrive(ledDrive), .seqBusy(seqBusy),
      .measureDone(measureDone));

   scs_adc_model adc (.mclk(mclk), .arst_n(arst_n), .adcStart(adcStart),
      .adcChannel(adcChannel), .latency(latency), .adcDone(adcDone),
      .adcSample(adcSample));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   // led drive and start count seen per slot
   always @(posedge mclk)
   begin
      if (adcStart === 1'b1)
      begin
         ledSeen[adcChannel] <= ledDrive;
         startCount[adcChannel] <= startCount[adcChannel] + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic wrap_up();
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string what, input logic [16:0] seen,
                        input logic [16:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrStrobe <= 1'b1;
      @(posedge mclk);
      regWrStrobe <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge mclk);
      regRdStrobe <= 1'b0;
      @(negedge mclk);
      d = regRdData;
   endtask

   function automatic int enBit(input logic [2:0] s);
      case (s)
         3'h0: return 4;
         3'h1: return 5;
         3'h2: return 0;
         3'h3: return 1;
         3'h4: return 2;
         default: return 6;
      endcase
   endfunction

   task automatic measure();
      int n;
      logic [7:0] st;
      @(posedge mclk);
      measureStart <= 1'b1;
      @(posedge mclk);
      measureStart <= 1'b0;
      @(negedge mclk);
      check("busy after start", seqBusy, 1'b1);
      repeat (3) @(posedge mclk);
      // a second request while busy must not restart the round
      measureStart <= 1'b1;
      @(posedge mclk);
      measureStart <= 1'b0;
      rd(OFS_SEQ_STATUS, st);
      check("status busy", st, 8'h01);
      for (n = 0; n < 500; n++)
      begin
         @(negedge mclk);
         if (measureDone === 1'b1)
            break;
      end
      check("round done", n < 500, 1'b1);
      check("busy at done", seqBusy, 1'b0);
      check("led idle", ledDrive, 3'h0);
      rd(OFS_SEQ_STATUS, st);
      check("status idle", st, 8'h00);
   endtask

   task automatic run_round(input logic [7:0] list, input logic [7:0] l12,
      input logic [7:0] l3, input logic [7:0] align, input logic [7:0] lat);
      logic [16:0] s;
      logic [7:0] lo, hi;
      logic [2:0] fld;
      latency <= lat;
      wr(OFS_CHANNEL_LIST, list);
      wr(OFS_LED_ONE_TWO, l12);
      wr(OFS_LED_THREE, l3);
      wr(OFS_ALIGNMENT, align);
      for (int i = 0; i < 6; i++)
      begin
         startCount[i] = 8'h00;
         ledSeen[i] = 3'h7;
      end
      measure();
      for (int i = 0; i < 6; i++)
      begin
         check("slot visits", startCount[i], list[enBit(i[2:0])]);
         if (list[enBit(i[2:0])])
         begin
            fld = i == 2 ? l12[2:0] : i == 3 ? l12[6:4] :
                  i == 4 ? l3[2:0] : 3'h0;
            check("led drive", ledSeen[i], fld);
            s = 17'h0c96b ^ {i[2:0], 14'h0000} ^ {14'h0000, i[2:0]};
            expWord[i] = (i >= 2 && i <= 4 && align[i + 2]) ?
                         s[15:0] : s[16:1];
            known[i] = 1'b1;
         end
         if (known[i])
         begin
            rd(OFS_RESULT_FIRST + 8'(2 * i), lo);
            rd(OFS_RESULT_FIRST + 8'(2 * i + 1), hi);
            check("result word", {hi, lo}, expWord[i]);
         end
      end
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      logic [7:0] d;
      logic [7:0] ofs [4];
      logic [7:0] rst [4];
      logic [7:0] msk [4];
      ofs = '{OFS_CHANNEL_LIST, OFS_LED_ONE_TWO, OFS_LED_THREE,
              OFS_ALIGNMENT};
      rst = '{RST_CHANNEL_LIST, RST_LED_ONE_TWO, RST_LED_THREE,
              RST_ALIGNMENT};
      msk = '{MASK_CHANNEL_LIST, MASK_LED_ONE_TWO, MASK_LED_THREE,
              MASK_ALIGNMENT};
      arst_n = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrStrobe = 1'b0;
      regRdStrobe = 1'b0;
      measureStart = 1'b0;
      latency = 8'h00;
      for (int i = 0; i < 6; i++)
         known[i] = 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         rd(ofs[i], d);
         check("reset value", d, rst[i]);
         wr(ofs[i], 8'hff);
         rd(ofs[i], d);
         check("writable bits", d, msk[i]);
         wr(ofs[i], 8'h88);
         rd(ofs[i], d);
         check("reserved bits", d, 8'h00);
      end
      wr(8'h04, 8'h5a);
      rd(8'h04, d);
      check("unmapped read", d, 8'h00);
      // zero channel list: a start request is refused
      @(posedge mclk);
      measureStart <= 1'b1;
      @(posedge mclk);
      measureStart <= 1'b0;
      @(negedge mclk);
      check("busy on empty list", seqBusy, 1'b0);
      run_round(8'h77, 8'h53, 8'h06, 8'h50, 8'h00);
      run_round(8'h12, 8'h70, 8'h01, 8'h20, 8'h07);
      run_round(8'h44, 8'h00, 8'h00, 8'h00, 8'h03);
      run_round(8'h21, 8'h16, 8'h05, 8'h70, 8'h01);
      wrap_up();
   end

   // watchdog far beyond the few hundred cycles the tests take
   initial
   begin
      repeat (20000) @(posedge mclk);
      fails++;
      wrap_up();
   end
endmodule
